// [pkg/uefc_pkg.sv]
// uefc_pkg: register indices, field positions, masks and reset values
// for the per-channel enhanced feature control block.
// assumes the register port addresses one 8-bit register per index.
package uefc_pkg;

	// ------------------------------------------------------------------
	// register indices on the register port
	// ------------------------------------------------------------------
	localparam logic [3:0] UEFC_IDX_WSC   = 4'h0; // tx/rx control, write side
	localparam logic [3:0] UEFC_IDX_SCR   = 4'h1; // scratch byte
	localparam logic [3:0] UEFC_IDX_FEATURE_CONTROL  = 4'h2; // feature control
	localparam logic [3:0] UEFC_IDX_EFS   = 4'h3; // enhanced feature select
	localparam logic [3:0] UEFC_IDX_START_FLOW_CHAR_1  = 4'h4;
	localparam logic [3:0] UEFC_IDX_START_FLOW_CHAR_2  = 4'h5;
	localparam logic [3:0] UEFC_IDX_STOP_FLOW_CHAR_1 = 4'h6;
	localparam logic [3:0] UEFC_IDX_STOP_FLOW_CHAR_2 = 4'h7;
	localparam logic [3:0] UEFC_IDX_MCR   = 4'h8; // modem control
	localparam logic [3:0] UEFC_IDX_IER   = 4'h9; // interrupt enable
	localparam logic [3:0] UEFC_IDX_FCR   = 4'ha; // fifo control

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int UEFC_WSC_NINE   = 0;
	localparam int UEFC_WSC_RXHALT = 2;
	localparam int UEFC_WSC_TXHALT = 3;
	localparam int UEFC_WSC_DLY_LO = 4;
	localparam int UEFC_FEATURE_CONTROL_IRINV = 4;
	localparam int UEFC_FEATURE_CONTROL_A485  = 5;
	localparam int UEFC_EFS_ENH    = 4;
	localparam int UEFC_EFS_SPC    = 5;
	localparam int UEFC_EFS_ARTS   = 6;
	localparam int UEFC_EFS_ACTS   = 7;
	localparam int UEFC_MCR_DTR    = 0;
	localparam int UEFC_MCR_RTS    = 1;
	localparam int UEFC_MCR_FSEL   = 2;

	// ------------------------------------------------------------------
	// enhanced bits, writable only while the enhance enable bit is set
	// ------------------------------------------------------------------
	localparam logic [7:0] UEFC_MASK_IER = 8'he0;
	localparam logic [7:0] UEFC_MASK_FCR = 8'h30;
	localparam logic [7:0] UEFC_MASK_MCR = 8'hec;
	localparam logic [7:0] UEFC_MASK_WSC = 8'hfc;

	// ------------------------------------------------------------------
	// reset values and flow selection codes
	// ------------------------------------------------------------------
	localparam logic [7:0] UEFC_RST_ZERO = 8'h00;
	localparam logic [7:0] UEFC_RST_SCR  = 8'hff;
	localparam logic [1:0] UEFC_SEL_NONE = 2'h0;
	localparam logic [1:0] UEFC_SEL_P2   = 2'h1;
	localparam logic [1:0] UEFC_SEL_P1   = 2'h2;
	localparam logic [1:0] UEFC_SEL_BOTH = 2'h3;

	typedef enum logic [1:0] {UEFC_DIR_IDLE, UEFC_DIR_SEND, UEFC_DIR_TURN} uefc_dir_t;

endpackage

// [hdl/uefc_ctrl.sv]
// uefc_ctrl: enhanced control of one serial channel: halts, 9-bit mode,
// scratch byte, half-duplex direction, flow control and char detect.
// assumes the tx/rx engines and fifos live outside and report through
// the engine ports; register port is synchronous to sys_clk_i.

module uefc_ctrl
	import uefc_pkg::*;
#(
	parameter int DLY_W = 4
)(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       bit_tick_i,
	input  wire logic       tx_load_i,
	input  wire logic       tx_fifo_empty_i,
	input  wire logic       tx_shift_busy_i,
	input  wire logic       rx_busy_i,
	input  wire logic       rx_char_valid_i,
	input  wire logic [7:0] rx_char_i,
	input  wire logic       rx_at_trigger_i,
	input  wire logic       rx_upper_i,
	input  wire logic       rx_lower_i,
	input  wire logic       rx_pin_i,
	input  wire logic       cts_n_i,
	input  wire logic       dsr_n_i,
	output logic            rx_line_o,
	output logic            tx_go_o,
	output logic            rx_enable_o,
	output logic            nine_bit_o,
	output logic            tx_irq_o,
	output logic            rx_trig_irq_o,
	output logic            rts_n_o,
	output logic            dtr_n_o,
	output logic            rx_store_o,
	output logic      [7:0] rx_store_data_o,
	output logic            xoff_irq_o,
	output logic            xon_det_o,
	output logic            special_irq_o,
	output logic      [1:0] tx_flow_sel_o
);

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic [7:0] wsc_r, scr_r, feature_control_r, efs_r, mcr_r, ier_r, fcr_r;
	logic [7:0] start_flow_char_1_r, start_flow_char_2_r, stop_flow_char_1_r, stop_flow_char_2_r;
	logic       enh;
	logic       wr_wsc, wr_mcr, wr_ier, wr_fcr;

	// keep gated bits unless enhance is on
	function automatic logic [7:0] uefc_merge(input logic [7:0] old_v,
		input logic [7:0] new_v, input logic [7:0] mask, input logic en);
		logic [7:0] keep;
		keep = en ? 8'h00 : mask;
		return (old_v & keep) | (new_v & ~keep);
	endfunction

	assign enh    = efs_r[UEFC_EFS_ENH];
	assign wr_wsc = reg_wr_i && (reg_addr_i == UEFC_IDX_WSC);
	assign wr_mcr = reg_wr_i && (reg_addr_i == UEFC_IDX_MCR);
	assign wr_ier = reg_wr_i && (reg_addr_i == UEFC_IDX_IER);
	assign wr_fcr = reg_wr_i && (reg_addr_i == UEFC_IDX_FCR);

	// gated registers; cleared by reset for legacy behaviour
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wsc_r <= UEFC_RST_ZERO;
			mcr_r <= UEFC_RST_ZERO;
			ier_r <= UEFC_RST_ZERO;
			fcr_r <= UEFC_RST_ZERO;
		end
		else
		begin
			// latched bits hold while enhance is off
			if (wr_wsc)
				wsc_r <= uefc_merge(wsc_r, reg_wdata_i, UEFC_MASK_WSC, enh);
			if (wr_mcr)
				mcr_r <= uefc_merge(mcr_r, reg_wdata_i, UEFC_MASK_MCR, enh);
			if (wr_ier)
				ier_r <= uefc_merge(ier_r, reg_wdata_i, UEFC_MASK_IER, enh);
			if (wr_fcr)
				fcr_r <= uefc_merge(fcr_r, reg_wdata_i, UEFC_MASK_FCR, enh);
		end
	end

	// plain registers: scratch, feature, select and flow characters
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scr_r   <= UEFC_RST_SCR;
			feature_control_r  <= UEFC_RST_ZERO;
			efs_r   <= UEFC_RST_ZERO;
			start_flow_char_1_r  <= UEFC_RST_ZERO;
			start_flow_char_2_r  <= UEFC_RST_ZERO;
			stop_flow_char_1_r <= UEFC_RST_ZERO;
			stop_flow_char_2_r <= UEFC_RST_ZERO;
		end
		else if (reg_wr_i)
		begin
			case (reg_addr_i)
				UEFC_IDX_SCR:   scr_r   <= reg_wdata_i;
				UEFC_IDX_FEATURE_CONTROL:  feature_control_r  <= reg_wdata_i & 8'h30;
				UEFC_IDX_EFS:   efs_r   <= reg_wdata_i;
				UEFC_IDX_START_FLOW_CHAR_1:  start_flow_char_1_r  <= reg_wdata_i;
				UEFC_IDX_START_FLOW_CHAR_2:  start_flow_char_2_r  <= reg_wdata_i;
				UEFC_IDX_STOP_FLOW_CHAR_1: stop_flow_char_1_r <= reg_wdata_i;
				UEFC_IDX_STOP_FLOW_CHAR_2: stop_flow_char_2_r <= reg_wdata_i;
				default:        ;
			endcase
		end
	end

	// read data; write-only registers read as zero
	// neither halt gates this port, so queued data stays readable
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= UEFC_RST_ZERO;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				UEFC_IDX_SCR:  reg_rdata_o <= scr_r;
				UEFC_IDX_FEATURE_CONTROL: reg_rdata_o <= feature_control_r;
				UEFC_IDX_EFS:  reg_rdata_o <= efs_r;
				UEFC_IDX_MCR:  reg_rdata_o <= mcr_r;
				UEFC_IDX_IER:  reg_rdata_o <= ier_r;
				UEFC_IDX_FCR:  reg_rdata_o <= fcr_r;
				default:       reg_rdata_o <= UEFC_RST_ZERO;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// pin synchronisers: three stages, change taken when 2nd and 3rd agree
	// ------------------------------------------------------------------
	logic [2:0] pin_raw, s1_r, s2_r, s3_r, pin_f_r;
	logic       rx_f, cts_f, dsr_f;

	assign pin_raw = {dsr_n_i, cts_n_i, rx_pin_i};

	// one process for all three pins, so each vector has a single driver
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_r    <= 3'h7;
			s2_r    <= 3'h7;
			s3_r    <= 3'h7;
			pin_f_r <= 3'h7;
		end
		else
		begin
			s1_r    <= pin_raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			// a bit moves only where the last two stages agree
			pin_f_r <= (s3_r & ~(s2_r ^ s3_r)) | (pin_f_r & (s2_r ^ s3_r));
		end
	end

	assign rx_f  = pin_f_r[0];
	assign cts_f = pin_f_r[1];
	assign dsr_f = pin_f_r[2];

	// ------------------------------------------------------------------
	// half-duplex direction with turnaround delay
	// ------------------------------------------------------------------
	uefc_dir_t  dir_r, dir_nxt;
	logic [DLY_W-1:0] dly_r, dly_nxt;
	logic       a485, tx_drained;

	assign a485       = feature_control_r[UEFC_FEATURE_CONTROL_A485];
	assign tx_drained = tx_fifo_empty_i && !tx_shift_busy_i;

	// a new load always wins over a pending turnaround
	always_comb
	begin
		dir_nxt = dir_r;
		dly_nxt = dly_r;
		case (dir_r)
			UEFC_DIR_IDLE:
				if (tx_load_i)
					dir_nxt = UEFC_DIR_SEND;
			UEFC_DIR_SEND:
				if (tx_drained)
				begin
					dly_nxt = wsc_r[UEFC_WSC_DLY_LO +: DLY_W];
					dir_nxt = (dly_nxt == '0) ? UEFC_DIR_IDLE : UEFC_DIR_TURN;
				end
			UEFC_DIR_TURN:
				if (tx_load_i)
					dir_nxt = UEFC_DIR_SEND;
				else if (bit_tick_i)
				begin
					dly_nxt = dly_r - 1'b1;
					if (dly_r == 1)
						dir_nxt = UEFC_DIR_IDLE;
				end
			default:
				dir_nxt = UEFC_DIR_IDLE;
		endcase
		if (!a485)
			dir_nxt = UEFC_DIR_IDLE;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dir_r <= UEFC_DIR_IDLE;
			dly_r <= '0;
		end
		else
		begin
			dir_r <= dir_nxt;
			dly_r <= dly_nxt;
		end
	end

	// ------------------------------------------------------------------
	// receive halt credit: one character may still complete
	// ------------------------------------------------------------------
	logic rx_halt, halt_q_r, credit_r, credit_nxt;

	assign rx_halt = wsc_r[UEFC_WSC_RXHALT];

	// a char in progress consumes the credit, otherwise the next one
	always_comb
	begin
		credit_nxt = credit_r;
		if (rx_halt && !halt_q_r)
			credit_nxt = 1'b1;
		else if (rx_char_valid_i || !rx_halt)
			credit_nxt = 1'b0;
	end

	// clearing while the line toggles may admit garbage; software's job
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			halt_q_r    <= 1'b0;
			credit_r    <= 1'b0;
			rx_enable_o <= 1'b1;
		end
		else
		begin
			halt_q_r    <= rx_halt;
			credit_r    <= credit_nxt;
			rx_enable_o <= !rx_halt || credit_nxt;
		end
	end

	// ------------------------------------------------------------------
	// software flow compare and special character detect
	// ------------------------------------------------------------------
	logic [1:0] rx_sel, tx_sel;
	logic       m_on1, m_on2, m_off1, m_off2, prev_on1_r, prev_off1_r;
	logic       hit_on, hit_off, spc, take, seq_mode;

	assign rx_sel   = efs_r[1:0];
	assign tx_sel   = efs_r[3:2];
	assign seq_mode = (rx_sel == UEFC_SEL_BOTH) && (tx_sel == UEFC_SEL_BOTH);
	assign take     = rx_char_valid_i && rx_enable_o;
	assign m_on1    = rx_char_i == start_flow_char_1_r;
	assign m_on2    = rx_char_i == start_flow_char_2_r;
	assign m_off1   = rx_char_i == stop_flow_char_1_r;
	assign m_off2   = rx_char_i == stop_flow_char_2_r;
	assign spc      = efs_r[UEFC_EFS_SPC] && m_off2;

	// decode of the receive selection into flow hits
	always_comb
	begin
		hit_on  = 1'b0;
		hit_off = 1'b0;
		case (rx_sel)
			UEFC_SEL_P1:
			begin
				hit_on  = m_on1;
				hit_off = m_off1;
			end
			UEFC_SEL_P2:
			begin
				hit_on  = m_on2;
				hit_off = m_off2;
			end
			UEFC_SEL_BOTH:
				if (seq_mode)
				begin
					hit_on  = prev_on1_r && m_on2;
					hit_off = prev_off1_r && m_off2;
				end
				else
				begin
					hit_on  = m_on1 || m_on2;
					hit_off = m_off1 || m_off2;
				end
			default: ;
		endcase
	end

	// flow chars are swallowed except the first of a sequence-mode pair; a plain special match is stored
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_on1_r      <= 1'b0;
			prev_off1_r     <= 1'b0;
			rx_store_o      <= 1'b0;
			rx_store_data_o <= UEFC_RST_ZERO;
			xoff_irq_o      <= 1'b0;
			xon_det_o       <= 1'b0;
			special_irq_o   <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				prev_on1_r  <= m_on1;
				prev_off1_r <= m_off1;
			end
			rx_store_o      <= take && !hit_on && !hit_off;
			rx_store_data_o <= rx_char_i;
			xoff_irq_o      <= take && hit_off;
			xon_det_o       <= take && hit_on;
			special_irq_o   <= take && spc;
		end
	end

	// ------------------------------------------------------------------
	// transmit gating: halt, hardware and software flow
	// ------------------------------------------------------------------
	logic sw_hold_r, hw_in;

	assign hw_in = mcr_r[UEFC_MCR_FSEL] ? dsr_f : cts_f;

	// a stop-flow char holds the transmitter until a start-flow char
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			sw_hold_r <= 1'b0;
		else if (rx_sel == UEFC_SEL_NONE)
			sw_hold_r <= 1'b0;
		else if (take && hit_off)
			sw_hold_r <= 1'b1;
		else if (take && hit_on)
			sw_hold_r <= 1'b0;
	end

	// shifter load permission; bytes stay queued in the tx fifo
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_go_o <= 1'b0;
		else
			tx_go_o <= !wsc_r[UEFC_WSC_TXHALT] && !sw_hold_r
				&& !(efs_r[UEFC_EFS_ACTS] && hw_in);
	end

	// ------------------------------------------------------------------
	// receive side hardware flow hold and pin outputs
	// ------------------------------------------------------------------
	logic hold_r, arts, rts_flow, dtr_flow;

	assign arts     = efs_r[UEFC_EFS_ARTS];
	assign rts_flow = arts && !mcr_r[UEFC_MCR_FSEL];
	assign dtr_flow = arts && mcr_r[UEFC_MCR_FSEL];

	// hysteresis between upper and lower trigger
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			hold_r <= 1'b0;
		else if (!arts || rx_lower_i)
			hold_r <= 1'b0;
		else if (rx_upper_i)
			hold_r <= 1'b1;
	end

	// direction control takes the rts pin over flow control
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rts_n_o       <= 1'b1;
			dtr_n_o       <= 1'b1;
			rx_line_o     <= 1'b1;
			nine_bit_o    <= 1'b0;
			tx_irq_o      <= 1'b0;
			rx_trig_irq_o <= 1'b0;
			tx_flow_sel_o <= UEFC_SEL_NONE;
		end
		else
		begin
			if (a485)
				rts_n_o <= dir_nxt != UEFC_DIR_IDLE;
			else
				rts_n_o <= !mcr_r[UEFC_MCR_RTS] || (rts_flow && hold_r);
			dtr_n_o       <= !mcr_r[UEFC_MCR_DTR] || (dtr_flow && hold_r);
			rx_line_o     <= rx_f ^ feature_control_r[UEFC_FEATURE_CONTROL_IRINV];
			nine_bit_o    <= wsc_r[UEFC_WSC_NINE];
			tx_irq_o      <= a485 ? tx_drained : tx_fifo_empty_i;
			rx_trig_irq_o <= arts && rx_at_trigger_i;
			tx_flow_sel_o <= tx_sel;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_tx_halt;
		@(posedge sys_clk_i) disable iff (rst_i)
		wsc_r[UEFC_WSC_TXHALT] |=> !tx_go_o;
	endproperty
	a_tx_halt: assert property (p_tx_halt)
		else $error("transmitter not stopped by halt");

	property p_rx_halt;
		@(posedge sys_clk_i) disable iff (rst_i)
		rx_halt && halt_q_r && !credit_r ##1 rx_halt |-> !rx_enable_o;
	endproperty
	a_rx_halt: assert property (p_rx_halt)
		else $error("receiver enabled after halt credit used");

	property p_nine;
		@(posedge sys_clk_i) disable iff (rst_i)
		wsc_r[UEFC_WSC_NINE] [*2] |-> nine_bit_o;
	endproperty
	a_nine: assert property (p_nine)
		else $error("nine bit mode output wrong");

	property p_scratch;
		@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == UEFC_IDX_SCR ##1 reg_rd_i && reg_addr_i == UEFC_IDX_SCR
		|=> reg_rdata_o == $past(reg_wdata_i, 2);
	endproperty
	a_scratch: assert property (p_scratch)
		else $error("scratch byte readback mismatch");

	property p_gate;
		@(posedge sys_clk_i) disable iff (rst_i)
		!enh && wr_wsc |=> wsc_r[7:2] == $past(wsc_r[7:2]);
	endproperty
	a_gate: assert property (p_gate)
		else $error("gated bits changed while enhance off");

	property p_dir_up;
		@(posedge sys_clk_i) disable iff (rst_i)
		a485 && tx_load_i |=> rts_n_o;
	endproperty
	a_dir_up: assert property (p_dir_up)
		else $error("direction output not raised on load");

	property p_cts;
		@(posedge sys_clk_i) disable iff (rst_i)
		efs_r[UEFC_EFS_ACTS] && !mcr_r[UEFC_MCR_FSEL] && cts_f |=> !tx_go_o;
	endproperty
	a_cts: assert property (p_cts)
		else $error("transmitter ran with cts high");

	property p_special;
		@(posedge sys_clk_i) disable iff (rst_i)
		take && efs_r[UEFC_EFS_SPC] && rx_sel == UEFC_SEL_P2 && m_off2
		|=> special_irq_o && xoff_irq_o && !rx_store_o;
	endproperty
	a_special: assert property (p_special)
		else $error("pair two special char handled wrong");

	property p_polarity;
		@(posedge sys_clk_i) disable iff (rst_i)
		!feature_control_r[UEFC_FEATURE_CONTROL_IRINV] && $stable(rx_f) ##1 $stable(rx_f) |-> rx_line_o == rx_f;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("receive polarity wrong");

	property p_txirq;
		@(posedge sys_clk_i) disable iff (rst_i)
		a485 && tx_shift_busy_i |=> !tx_irq_o;
	endproperty
	a_txirq: assert property (p_txirq)
		else $error("tx interrupt while shifter busy");

endmodule // uefc_ctrl

// [tb/uefc_line_model.sv]
// uefc_line_model: far-side modem or transceiver seen at the pins
// assumes bench commands change just after a rising sys_clk_i edge
module uefc_line_model
#(
	parameter int LAG = 2
)(
	input  wire logic sys_clk_i,
	input  wire logic stop_i,
	input  wire logic brk_i,
	output logic      rx_pin_o,
	output logic      cts_n_o,
	output logic      dsr_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------
	// handshake
	// ------
	logic [LAG-1:0] lag_r = '0;

	// a slow modem answers a stop request only after a few cycles
	always_ff @(posedge sys_clk_i)
		lag_r <= {lag_r[LAG-2:0], stop_i};

	assign cts_n_o = lag_r[LAG-1];
	assign dsr_n_o = lag_r[LAG-1];

	// line idles high so a receiver re-enable never sees a toggling line
	assign rx_pin_o = !brk_i;

endmodule // uefc_line_model

// [tb/uefc_ctrl_tb_top.sv]
// uefc_ctrl_tb_top: register and pin level checks of uefc_ctrl
// assumes uefc_pkg and uefc_ctrl are compiled before this file
module uefc_ctrl_tb_top;
	import uefc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ------
	// stimulus and observed signals
	// ------
	logic       clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00, ch = 8'h00, rdat, sd;
	logic       tick = 1'h0, load = 1'h0, fe = 1'h1, busy = 1'h0, cv = 1'h0;
	logic       trg = 1'h0, up = 1'h0, lo = 1'h0, stp = 1'h0, brk = 1'h0;
	logic       rxp, cts_n, dsr_n, rxl, go, rxe, nine, tirq, trirq;
	logic       rts_n, dtr_n, st, xo, xn, sp;
	logic [1:0] tfs;
	int         num_errors = 0, check_count = 0, cyc = 0;

	always #12.5 clk = ~clk;

	uefc_ctrl #(.DLY_W(4)) dut_u (
		.sys_clk_i(clk), .rst_i(rst), .reg_wr_i(we), .reg_rd_i(re),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.bit_tick_i(tick), .tx_load_i(load), .tx_fifo_empty_i(fe),
		.tx_shift_busy_i(busy), .rx_busy_i(1'h0), .rx_char_valid_i(cv),
		.rx_char_i(ch), .rx_at_trigger_i(trg), .rx_upper_i(up),
		.rx_lower_i(lo), .rx_pin_i(rxp), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
		.rx_line_o(rxl), .tx_go_o(go), .rx_enable_o(rxe), .nine_bit_o(nine),
		.tx_irq_o(tirq), .rx_trig_irq_o(trirq), .rts_n_o(rts_n),
		.dtr_n_o(dtr_n), .rx_store_o(st), .rx_store_data_o(sd),
		.xoff_irq_o(xo), .xon_det_o(xn), .special_irq_o(sp),
		.tx_flow_sel_o(tfs)
	);

	uefc_line_model #(.LAG(3)) far_u (
		.sys_clk_i(clk), .stop_i(stp), .brk_i(brk),
		.rx_pin_o(rxp), .cts_n_o(cts_n), .dsr_n_o(dsr_n)
	);

	// ------
	// tasks
	// ------
	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'h1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'h0;
	endtask

	// data is registered, so it is looked at one edge after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		re <= 1'h1;
		addr <= a;
		@(posedge clk);
		re <= 1'h0;
		@(posedge clk);
		#1 ck(rdat, e);
	endtask

	task automatic cy(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic rx(input logic [7:0] c);
		@(posedge clk);
		cv <= 1'h1;
		ch <= c;
		@(posedge clk);
		cv <= 1'h0;
		#1;
	endtask

	task automatic tk;
		@(posedge clk);
		tick <= 1'h1;
		@(posedge clk);
		tick <= 1'h0;
		#1;
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			num_errors++;
			wrap_up;
		end
	end

	// ------
	// test sequence
	// ------
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		cy(1);
		rd(UEFC_IDX_SCR, UEFC_RST_SCR);
		rd(UEFC_IDX_EFS, 8'h00);
		rd(UEFC_IDX_MCR, 8'h00);
		wr(UEFC_IDX_SCR, 8'ha5);
		rd(UEFC_IDX_SCR, 8'ha5);
		rd(4'hf, 8'h00);
		wr(UEFC_IDX_STOP_FLOW_CHAR_2, 8'h13);
		rd(UEFC_IDX_STOP_FLOW_CHAR_2, 8'h00);
		$display("registers done");
		// gated bits must keep their latched values while enhance is off
		wr(UEFC_IDX_IER, 8'hff);
		rd(UEFC_IDX_IER, ~UEFC_MASK_IER);
		wr(UEFC_IDX_MCR, 8'hff);
		rd(UEFC_IDX_MCR, ~UEFC_MASK_MCR);
		wr(UEFC_IDX_EFS, 8'h10);
		wr(UEFC_IDX_IER, 8'hff);
		rd(UEFC_IDX_IER, 8'hff);
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_IER, 8'h00);
		rd(UEFC_IDX_IER, UEFC_MASK_IER);
		wr(UEFC_IDX_WSC, 8'hfd);
		cy(1);
		ck(8'({go, nine}), 8'h3);
		$display("gating done");
		// transmit and receive halts, 9-bit select
		wr(UEFC_IDX_EFS, 8'h10);
		wr(UEFC_IDX_WSC, 8'h09);
		cy(1);
		ck(8'({go, nine}), 8'h1);
		wr(UEFC_IDX_WSC, 8'h04);
		cy(1);
		ck(8'({go, rxe}), 8'h3);
		rx(8'h41);
		ck({st, sd[6:0]}, 8'hc1);
		cy(1);
		ck(8'(rxe), 8'h0);
		rx(8'h42);
		ck(8'(st), 8'h0);
		wr(UEFC_IDX_WSC, 8'h00);
		cy(1);
		ck(8'(rxe), 8'h1);
		$display("halts done");
		// special char and software flow selections
		wr(UEFC_IDX_EFS, 8'h21);
		rx(8'h13);
		ck(8'({st, xo, sp}), 8'h3);
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_EFS, 8'h22);
		rx(8'h13);
		ck(8'({st, xo, sp}), 8'h5);
		wr(UEFC_IDX_STOP_FLOW_CHAR_1, 8'h11);
		wr(UEFC_IDX_START_FLOW_CHAR_1, 8'h12);
		wr(UEFC_IDX_START_FLOW_CHAR_2, 8'h14);
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_EFS, 8'h0a);
		rx(8'h11);
		ck(8'({st, xo}), 8'h1);
		cy(1);
		ck(8'({go, tfs}), 8'h2);
		rx(8'h12);
		ck(8'(xn), 8'h1);
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_EFS, 8'h03);
		rx(8'h14);
		ck(8'(xn), 8'h1);
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_EFS, 8'h0f);
		rx(8'h12);
		ck(8'({st, xn}), 8'h2);
		rx(8'h14);
		ck(8'({st, xn, tfs}), 8'h7);
		$display("flow chars done");
		// hardware flow: general output, then automatic request and clear
		wr(UEFC_IDX_EFS, 8'h00);
		wr(UEFC_IDX_MCR, 8'h03);
		cy(1);
		ck(8'({rts_n, dtr_n}), 8'h0);
		wr(UEFC_IDX_EFS, 8'h40);
		@(posedge clk);
		trg <= 1'h1;
		up <= 1'h1;
		cy(2);
		ck(8'({trirq, rts_n}), 8'h3);
		@(posedge clk);
		lo <= 1'h1;
		cy(2);
		ck(8'(rts_n), 8'h0);
		wr(UEFC_IDX_EFS, 8'h80);
		@(posedge clk);
		trg <= 1'h0;
		up <= 1'h0;
		lo <= 1'h0;
		stp <= 1'h1;
		cy(10);
		ck(8'(go), 8'h0);
		@(posedge clk);
		stp <= 1'h0;
		cy(10);
		ck(8'(go), 8'h1);
		$display("hardware flow done");
		// receive polarity, with the far side breaking the line
		wr(UEFC_IDX_FEATURE_CONTROL, 8'h10);
		rd(UEFC_IDX_FEATURE_CONTROL, 8'h10);
		ck(8'(rxl), 8'h0);
		@(posedge clk);
		brk <= 1'h1;
		cy(8);
		ck(8'(rxl), 8'h1);
		$display("polarity done");
		// half-duplex direction with a two bit-time turnaround
		wr(UEFC_IDX_EFS, 8'h10);
		wr(UEFC_IDX_WSC, 8'h20);
		wr(UEFC_IDX_FEATURE_CONTROL, 8'h20);
		@(posedge clk);
		brk <= 1'h0;
		load <= 1'h1;
		fe <= 1'h0;
		busy <= 1'h1;
		@(posedge clk);
		load <= 1'h0;
		cy(1);
		ck(8'({tirq, rts_n}), 8'h1);
		tk;
		@(posedge clk);
		fe <= 1'h1;
		cy(1);
		ck(8'({tirq, rts_n}), 8'h1);
		@(posedge clk);
		busy <= 1'h0;
		cy(3);
		ck(8'({tirq, rts_n}), 8'h3);
		tk;
		ck(8'(rts_n), 8'h1);
		tk;
		cy(1);
		ck(8'(rts_n), 8'h0);
		wr(UEFC_IDX_FEATURE_CONTROL, 8'h00);
		@(posedge clk);
		busy <= 1'h1;
		cy(2);
		ck(8'(tirq), 8'h1);
		$display("direction done");
		wrap_up;
	end

endmodule // uefc_ctrl_tb_top
